// ---- rtl/bcf_regs.sv ----
// Channel 2 configuration, safety reaction and channel 3 fault status registers
// Functional notes
// - A fault with reaction code 00 (reset) turns off all half-bridge drivers and charge pumps and enters safe-off.
// - A fault with reaction code 01 disables only the failing half-bridge and keeps normal mode.
// - A fault with reaction code 10 or 11 only raises a warning and keeps normal mode.
// - The activity measure enable at bit 11 of the third config word resets to 0 and a written 1 enables it.
`timescale 1ns/100ps
`default_nettype none
module bcf_regs
  import bcf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_err,
  input wire bcf_fault_t ch2_fault,
  input wire logic fault_ack,
  input wire logic [10:0] activity_result_value,
  input wire logic activity_result_overflow,
  input wire logic activity_valid,
  input wire bcf_ch3_level_t ch3_level,
  input wire bcf_ch3_event_t ch3_event,
  output logic activity_measure_enable,
  output logic [10:0] sync_period_setting,
  output logic safe_off,
  output logic charge_pumps_off,
  output logic [2:0] half_bridge_off,
  output logic half_bridge2_off,
  output logic fault_warning
);
  logic [15:0] cfg3_r;
  logic [15:0] safety_r;
  logic [15:0] act_r;
  logic [15:0] ch3_stat_r;
  logic [15:0] ch3_stat_nxt;
  logic safe_off_r;
  logic hb2_off_r;
  logic warn_r;
  logic [15:0] rdata_nxt;

  // Address decode
  wire logic hit_cfg3 = (reg_addr == BCF_OFS_CFG3);
  wire logic hit_safety = (reg_addr == BCF_OFS_SAFETY);
  wire logic hit_act = (reg_addr == BCF_OFS_ACT);
  wire logic hit_stat = (reg_addr == BCF_OFS_CH3_STAT1);
  wire logic hit_any = hit_cfg3 || hit_safety || hit_act || hit_stat;
  wire logic wr_cfg3 = reg_wr && hit_cfg3;
  wire logic wr_safety = reg_wr && hit_safety;
  wire logic rd_stat = reg_rd && hit_stat;

  // Reaction fields of the safety word
  wire logic [1:0] stp_mode = safety_r[BCF_POS_STP_REACT +: 2];
  wire logic [1:0] ls_mode = safety_r[BCF_POS_LS_REACT +: 2];
  wire logic [1:0] hs_mode = safety_r[BCF_POS_HS_REACT +: 2];

  bcf_react_t stp_react;
  bcf_react_t ls_react;
  bcf_react_t hs_react;

  // One decoder per fault source, all on the same coding
  bcf_reaction u_stp (
    .fault(ch2_fault.stp_vgs),
    .mode(stp_mode),
    .react(stp_react)
  );
  bcf_reaction u_ls (
    .fault(ch2_fault.ls_stb),
    .mode(ls_mode),
    .react(ls_react)
  );
  bcf_reaction u_hs (
    .fault(ch2_fault.hs_stg),
    .mode(hs_mode),
    .react(hs_react)
  );

  wire logic any_shutdown = stp_react.shutdown || ls_react.shutdown || hs_react.shutdown;
  wire logic any_bridge_off = stp_react.bridge_off || ls_react.bridge_off || hs_react.bridge_off;
  wire logic any_warn = stp_react.warn || ls_react.warn || hs_react.warn;

  // Config words
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg3_r <= BCF_RST_CFG3;
      safety_r <= BCF_RST_SAFETY;
    end
    else
    begin
      if (wr_cfg3)
        cfg3_r <= reg_wdata;
      if (wr_safety)
        safety_r <= reg_wdata;
    end
  end

  // Activity result, updated only while measurement runs
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      act_r <= BCF_RST_ACT;
    else if (activity_valid && cfg3_r[BCF_POS_ACT_EN])
      act_r <= {4'h0, activity_result_overflow, activity_result_value};
  end

  // Channel 3 status: level bits follow, event bits stick until read, set wins
  always_comb
  begin
    ch3_stat_nxt = ch3_stat_r;
    if (rd_stat)
    begin
      ch3_stat_nxt[BCF_POS_LS3_STB] = 1'b0;
      ch3_stat_nxt[BCF_POS_HS3_STG] = 1'b0;
      ch3_stat_nxt[BCF_POS_SPARE_CR] = 1'b0;
      ch3_stat_nxt[BCF_POS_STP3] = 1'b0;
      ch3_stat_nxt[BCF_POS_AUX_CR] = 1'b0;
    end
    ch3_stat_nxt[BCF_POS_LS3_STB] = ch3_stat_nxt[BCF_POS_LS3_STB] | ch3_event.ls_stb;
    ch3_stat_nxt[BCF_POS_HS3_STG] = ch3_stat_nxt[BCF_POS_HS3_STG] | ch3_event.hs_stg;
    ch3_stat_nxt[BCF_POS_SPARE_CR] = ch3_stat_nxt[BCF_POS_SPARE_CR] | ch3_event.spare;
    ch3_stat_nxt[BCF_POS_STP3] = ch3_stat_nxt[BCF_POS_STP3] | ch3_event.stp_vgs;
    ch3_stat_nxt[BCF_POS_AUX_CR] = ch3_stat_nxt[BCF_POS_AUX_CR] | ch3_event.aux;
    ch3_stat_nxt[BCF_POS_LS3_OFF] = ch3_level.ls_off;
    ch3_stat_nxt[BCF_POS_HS3_OFF] = ch3_level.hs_off;
    ch3_stat_nxt[BCF_POS_LS3_OFD] = ch3_level.ls_ofd;
    ch3_stat_nxt[BCF_POS_HS3_OFD] = ch3_level.hs_ofd;
    ch3_stat_nxt[BCF_POS_AUX_RO] = ch3_level.aux_ro;
    ch3_stat_nxt[15:10] = 6'h00;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ch3_stat_r <= BCF_RST_CH3_STAT1;
    else
      ch3_stat_r <= ch3_stat_nxt;
  end

  // Fault reaction state: safe-off holds until reset, others until acknowledged
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      safe_off_r <= 1'b0;
      hb2_off_r <= 1'b0;
      warn_r <= 1'b0;
    end
    else
    begin
      if (any_shutdown)
        safe_off_r <= 1'b1;
      hb2_off_r <= any_bridge_off || (hb2_off_r && !fault_ack);
      warn_r <= any_warn || (warn_r && !fault_ack);
    end
  end

  // Read data mux, registered
  assign rdata_nxt = hit_cfg3 ? cfg3_r :
                     hit_safety ? safety_r :
                     hit_act ? act_r :
                     hit_stat ? ch3_stat_r : 16'h0000;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 16'h0000;
      reg_err <= 1'b0;
    end
    else if (reg_rd || reg_wr)
    begin
      reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
      reg_err <= !hit_any || (reg_wr && (hit_act || hit_stat));
    end
  end

  // Outputs
  assign activity_measure_enable = cfg3_r[BCF_POS_ACT_EN];
  assign sync_period_setting = cfg3_r[BCF_POS_SYNC_LO +: BCF_SYNC_W];
  assign safe_off = safe_off_r;
  assign charge_pumps_off = safe_off_r;
  assign half_bridge_off = {3{safe_off_r}};
  assign half_bridge2_off = safe_off_r || hb2_off_r;
  assign fault_warning = warn_r;
endmodule
`default_nettype wire

// ---- rtl/bcf_pkg.sv ----
// Package with register map, field layout and types of the channel fault configuration block
package bcf_pkg;
  // Register offsets
  localparam logic [7:0] BCF_OFS_CFG3 = 8'h2c;
  localparam logic [7:0] BCF_OFS_SAFETY = 8'h2d;
  localparam logic [7:0] BCF_OFS_ACT = 8'h2e;
  localparam logic [7:0] BCF_OFS_CH3_STAT1 = 8'h30;
  // Reset values
  localparam logic [15:0] BCF_RST_CFG3 = 16'h0000;
  localparam logic [15:0] BCF_RST_SAFETY = 16'h0017;
  localparam logic [15:0] BCF_RST_ACT = 16'h0000;
  localparam logic [15:0] BCF_RST_CH3_STAT1 = 16'h0000;
  // Field positions in the third configuration word
  localparam int BCF_POS_ACT_EN = 11;
  localparam int BCF_POS_SYNC_LO = 0;
  localparam int BCF_SYNC_W = 11;
  // Field positions in the safety word (low bit of each 2-bit field)
  localparam int BCF_POS_STP_REACT = 11;
  localparam int BCF_POS_LS_REACT = 7;
  localparam int BCF_POS_HS_REACT = 5;
  localparam int BCF_POS_CRC = 0;
  localparam int BCF_CRC_W = 5;
  // Field positions in the activity result
  localparam int BCF_POS_ACT_OVF = 11;
  localparam int BCF_ACT_W = 11;
  // Field positions in the channel 3 status word
  localparam int BCF_POS_LS3_OFF = 9;
  localparam int BCF_POS_HS3_OFF = 8;
  localparam int BCF_POS_LS3_STB = 7;
  localparam int BCF_POS_HS3_STG = 6;
  localparam int BCF_POS_LS3_OFD = 5;
  localparam int BCF_POS_HS3_OFD = 4;
  localparam int BCF_POS_SPARE_CR = 3;
  localparam int BCF_POS_STP3 = 2;
  localparam int BCF_POS_AUX_CR = 1;
  localparam int BCF_POS_AUX_RO = 0;
  // Reaction encoding
  typedef enum logic [1:0] {
    BCF_REACT_FULL_OFF = 2'h0,
    BCF_REACT_BRIDGE_ONLY = 2'h1,
    BCF_REACT_FLAG_A = 2'h2,
    BCF_REACT_FLAG_B = 2'h3
  } bcf_react_mode_t;
  // One-cycle fault events of a channel
  typedef struct packed {
    logic stp_vgs;
    logic ls_stb;
    logic hs_stg;
  } bcf_fault_t;
  // Decoded reaction of one fault
  typedef struct packed {
    logic shutdown;
    logic bridge_off;
    logic warn;
  } bcf_react_t;
  // Channel 3 level status inputs
  typedef struct packed {
    logic ls_off;
    logic hs_off;
    logic ls_ofd;
    logic hs_ofd;
    logic aux_ro;
  } bcf_ch3_level_t;
  // Channel 3 event inputs, caught in clear-on-read bits
  typedef struct packed {
    logic ls_stb;
    logic hs_stg;
    logic spare;
    logic stp_vgs;
    logic aux;
  } bcf_ch3_event_t;
endpackage

// ---- rtl/bcf_reaction.sv ----
// Reaction decoder for one fault event of a half-bridge channel
`timescale 1ns/100ps
`default_nettype none
module bcf_reaction
  import bcf_pkg::*;
(
  input wire logic fault,
  input wire logic [1:0] mode,
  output bcf_react_t react
);
  // Select the reaction from the configured mode
  wire logic is_full = (mode == BCF_REACT_FULL_OFF);
  wire logic is_bridge = (mode == BCF_REACT_BRIDGE_ONLY);
  wire logic is_flag = (mode == BCF_REACT_FLAG_A) || (mode == BCF_REACT_FLAG_B);
  assign react.shutdown = fault && is_full;
  assign react.bridge_off = fault && is_bridge;
  assign react.warn = fault && is_flag;
endmodule
`default_nettype wire

// ---- tb/bcf_regs_sva.sv ----
// Port assertions for the channel fault configuration block
`timescale 1ns/100ps
`default_nettype none
module bcf_regs_sva
  import bcf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire bcf_fault_t ch2_fault,
  input wire logic fault_ack,
  input wire logic activity_measure_enable,
  input wire logic [10:0] sync_period_setting,
  input wire logic safe_off,
  input wire logic charge_pumps_off,
  input wire logic [2:0] half_bridge_off,
  input wire logic half_bridge2_off,
  input wire logic fault_warning
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [15:0] safety_r;
  // Shadow of the safety word, seen from bus writes
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      safety_r <= BCF_RST_SAFETY;
    else if (reg_wr && reg_addr == BCF_OFS_SAFETY)
      safety_r <= reg_wdata;
  end
  // Lone shoot-through event with no acknowledge
  sequence s_lone_stp;
    ch2_fault == 3'h4 && !fault_ack && !safe_off;
  endsequence
  a_full_off_react: assert property (s_lone_stp ##0 safety_r[12:11] == 2'h0
    |=> safe_off && charge_pumps_off && half_bridge_off == 3'h7) else $error("no full off");
  a_reduced_react: assert property (s_lone_stp ##0 safety_r[12:11] == 2'h1
    |=> half_bridge2_off && !safe_off) else $error("no reduced mode");
  a_warn_only: assert property (s_lone_stp ##0 safety_r[12]
    |=> fault_warning && !safe_off && half_bridge2_off == $past(half_bridge2_off))
    else $error("warning reaction wrong");
  a_ls_short_off: assert property (ch2_fault == 3'h2 && safety_r[8:7] == 2'h0
    |=> safe_off) else $error("low side short no off");
  a_enable_write: assert property (reg_wr && reg_addr == BCF_OFS_CFG3
    |=> activity_measure_enable == $past(reg_wdata[11])) else $error("enable not written");
  a_cfg_readback: assert property (reg_rd && !reg_wr && reg_addr == BCF_OFS_CFG3
    |=> reg_rdata[11:0] == {activity_measure_enable, sync_period_setting})
    else $error("cfg3 read wrong");
  a_safety_read: assert property (reg_rd && !reg_wr && reg_addr == BCF_OFS_SAFETY
    |=> reg_rdata == $past(safety_r)) else $error("safety read wrong");
  a_safe_sticky: assert property (safe_off |=> safe_off && charge_pumps_off)
    else $error("safe off dropped");
  a_bridges_follow: assert property (half_bridge_off == {3{safe_off}})
    else $error("bridges differ from safe off");
endmodule
bind bcf_regs bcf_regs_sva u_bcf_regs_sva (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .ch2_fault, .fault_ack, .activity_measure_enable,
  .sync_period_setting, .safe_off, .charge_pumps_off, .half_bridge_off,
  .half_bridge2_off, .fault_warning);
`default_nettype wire

// ---- tb/bcf_host.sv ----
// Host model driving the register access strobes
`timescale 1ns/100ps
`default_nettype none
module bcf_host
(
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
  end
  // One access: strobe for one cycle, then invert released lines
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- tb/bcf_regs_bench.sv ----
// Testbench for the channel fault configuration registers
`timescale 1ns/100ps
`default_nettype none
module bcf_regs_bench
  import bcf_pkg::*;
;
  // Clock starts at its idle level so no false falling edge appears at time zero
  logic mclk = 1'b0;
  logic rst_b, reg_wr, reg_rd, reg_err, fault_ack, activity_valid;
  logic activity_result_overflow, activity_measure_enable, safe_off, charge_pumps_off;
  logic half_bridge2_off, fault_warning;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  logic [10:0] activity_result_value, sync_period_setting;
  logic [2:0] half_bridge_off;
  bcf_fault_t ch2_fault;
  bcf_ch3_level_t ch3_level;
  bcf_ch3_event_t ch3_event;
  int err_count = 0;
  int check_count = 0;
  bcf_regs u_bcf_regs (.mclk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_err, .ch2_fault, .fault_ack, .activity_result_value, .activity_result_overflow,
    .activity_valid, .ch3_level, .ch3_event, .activity_measure_enable, .sync_period_setting,
    .safe_off, .charge_pumps_off, .half_bridge_off, .half_bridge2_off, .fault_warning);
  bcf_host u_bcf_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  // Clock at 200 MHz
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_bcf_host.xfer(1'b0, a, 16'h0, q);
    chk("read data", e, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_bcf_host.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse_fault(input bcf_fault_t f);
    @(negedge mclk);
    ch2_fault = f;
    @(negedge mclk);
    ch2_fault = '0;
  endtask
  task automatic do_reset();
    rst_b = 0;
    repeat (3) @(negedge mclk);
    rst_b = 1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung run
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    {rst_b, fault_ack, activity_valid, activity_result_overflow} = '0;
    {activity_result_value, ch2_fault, ch3_level, ch3_event} = '0;
    do_reset();
    rd(BCF_OFS_CFG3, 16'h0000);
    rd(BCF_OFS_SAFETY, 16'h0017);
    rd(BCF_OFS_ACT, 16'h0000);
    rd(8'h2f, 16'h0000);
    chk("unmapped err", 16'h1, reg_err);
    wr(BCF_OFS_CFG3, 16'h0fff);
    chk("enable", 16'h1, activity_measure_enable);
    chk("sync period", 16'h07ff, 16'(sync_period_setting));
    rd(BCF_OFS_CFG3, 16'h0fff);
    @(negedge mclk);
    {activity_valid, activity_result_overflow, activity_result_value} = {2'h3, 11'h5a5};
    @(negedge mclk);
    activity_valid = 0;
    rd(BCF_OFS_ACT, 16'h0da5);
    wr(BCF_OFS_ACT, 16'h0000);
    chk("read-only err", 16'h1, reg_err);
    ch3_level = 5'h1f;
    ch3_event = 5'h1f;
    @(negedge mclk);
    ch3_event = '0;
    rd(BCF_OFS_CH3_STAT1, 16'h03ff);
    rd(BCF_OFS_CH3_STAT1, 16'h0331);
    // Each shoot-through reaction code from a fresh reset
    for (int m = 0; m < 4; m++)
    begin
      do_reset();
      wr(BCF_OFS_SAFETY, {3'h0, m[1:0], 11'h017});
      pulse_fault(3'h4);
      chk("safe off", 16'(m == 0), safe_off);
      chk("bridge two off", 16'(m < 2), half_bridge2_off);
      chk("warning", 16'(m > 1), fault_warning);
      fault_ack = 1;
      @(negedge mclk);
      fault_ack = 0;
      chk("bridge two after ack", 16'(m == 0), half_bridge2_off);
      chk("warning after ack", 16'h0, fault_warning);
    end
    // Short reactions on the other codes: low side reduced, high side warning only
    do_reset();
    wr(BCF_OFS_SAFETY, 16'h00d7);
    chk("write err", 16'h0, reg_err);
    pulse_fault(3'h2);
    chk("low side short reduced", 16'h1, half_bridge2_off);
    pulse_fault(3'h1);
    chk("high side short warning", 16'h1, fault_warning);
    chk("no safe off", 16'h0, safe_off);
    do_reset();
    pulse_fault(3'h2);
    chk("low side short off", 16'h1, safe_off);
    do_reset();
    pulse_fault(3'h1);
    chk("high side short off", 16'h1, charge_pumps_off);
    give_verdict();
  end
endmodule
`default_nettype wire
